// ==== design/ccu_pkg.sv ====
package ccu_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] UNIT_STRIDE = 8'h20;
  localparam logic [7:0] UNIT_SPAN_END = 8'h40;
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_TRIG = 5'h04;
  localparam logic [4:0] OFS_VLO = 5'h08;
  localparam logic [4:0] OFS_VHI = 5'h0C;
  localparam logic [7:0] OFS_TSEL = 8'h40;
  localparam logic [7:0] OFS_PEND = 8'h44;
  localparam logic [7:0] OFS_ENAB = 8'h48;
  localparam logic [7:0] OFS_STAT = 8'h4C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************
  // Field layouts and reset values
  // ****************************************
  typedef struct packed {
    logic conv_sel;
    logic pin_dir;
    logic open_drain;
    logic [3:0] mode;
  } ccu_ctrl_s;
  typedef struct packed {
    ccu_ctrl_s ctrl;
    logic [3:0] trig;
    logic [1:0] tsel;
  } ccu_cfg_s;
  typedef struct packed {
    logic [15:0] first;
    logic [15:0] third;
    logic [15:0] fifth;
  } ccu_timers_s;
  localparam ccu_ctrl_s CTRL_RST = 7'h20;
  localparam logic [3:0] TRIG_RST = 4'h0;
  localparam logic [1:0] TSEL_RST = 2'h0;
  localparam logic [15:0] VALUE_RST = 16'h0000;
  // ****************************************
  // Mode, source and timer codes
  // ****************************************
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CMP_TGL_CLR = 4'h1;
  localparam logic [3:0] MODE_CMP_TGL = 4'h2;
  localparam logic [3:0] MODE_CAP_ANY = 4'h3;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_R4 = 4'h6;
  localparam logic [3:0] MODE_CAP_R16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR = 4'h9;
  localparam logic [3:0] MODE_CMP_PLS = 4'hA;
  localparam logic [3:0] MODE_CMP_PLS_CLR = 4'hB;
  localparam logic [3:0] TRIG_PIN = 4'h0;
  localparam logic [3:0] TRIG_CMP1 = 4'h1;
  localparam logic [3:0] TRIG_CMP2 = 4'h2;
  localparam logic [3:0] TRIG_IOC = 4'h3;
  localparam logic [1:0] TSEL_FIRST = 2'h0;
  localparam logic [1:0] TSEL_THIRD = 2'h1;
  localparam logic [1:0] TSEL_FIFTH = 2'h2;
  localparam logic [1:0] PSC4_LAST = 2'h3;
  localparam logic [3:0] PSC16_LAST = 4'hF;
endpackage

// ==== design/ccu_top.sv ====
// Contract
// [R1] Each unit has its own timer select; default selects the first wide timer.
// [R2] Capture and compare use the first, third or fifth wide timer only.
// [R3] Both units may run together and share one timer.
// [R4] Compare pin driver offers an optional open-drain configuration.
// [R5] Qualified capture copies the full 16-bit timer; read as low and high byte.
// [R6] Capture qualifier: falling, rising, every 4th rising, 16th rising, any edge.
// [R7] Each capture sets the event flag; only software clears it.
// [R8] A new capture overwrites the previous captured value.
// [R9] Software disables the unit or reads both bytes twice for consistency.
// [R10] Pin input path sees the pin level, so own output writes can capture.
// [R11] Trigger source field selects pin, comparators, change signal or logic cells.
// [R12] Selected timer must run in timer or synchronized counter mode.
// [R13] Software keeps the enable clear and clears the flag after mode change.
// [R14] Capture timer is clocked from instruction clock or external source.
// [R15] Edge prescaler clears when off, outside capture mode, and on reset.
// [R16] Changing prescaler setting keeps the count; software clears control first.
// [R17] In sleep, only units on externally clocked timers keep working.
// [R18] Compare matches value to timer and toggles, sets, clears or pulses.
// [R19] Every compare match sets the flag and may issue a conversion trigger.
// [R20] Modes 0001 and 1011 clear the selected timer on match.
// [R21] Clearing control forces the compare output latch low.
// [R22] Compare output is also offered internally to other peripherals.
// [R23] Remaining mode codes are distinct values for off, captures and compares.
//
// Design decisions made here: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps

module ccu_unit
  import ccu_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Configuration and timers
  input wire ccu_pkg::ccu_cfg_s cfg,
  input wire ccu_pkg::ccu_timers_s timers,
  input wire logic [2:0] timer_ext_clk,
  input wire logic sleep_mode,
  // Trigger sources
  input wire logic pin_in,
  input wire logic cmp_one,
  input wire logic cmp_two,
  input wire logic pin_chg,
  input wire logic [7:0] cells,
  // Value byte writes
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [7:0] wbyte,
  // Results
  output logic [15:0] value,
  output logic event_p,
  output logic tmr_clr,
  output logic conv_trig,
  output logic cmp_out,
  output logic pin_out,
  output logic pin_oe
);
  import ccu_pkg::*;

  // ****************************************
  // State
  // ****************************************
  logic pin_meta;
  logic pin_sync;
  logic src_prev;
  logic [3:0] psc_cnt;
  logic match_prev;
  logic pulse_on;

  // ****************************************
  // Mode decode
  // ****************************************
  wire [3:0] mode = cfg.ctrl.mode;
  wire m_any = (mode == MODE_CAP_ANY);
  wire m_fall = (mode == MODE_CAP_FALL);
  wire m_rise = (mode == MODE_CAP_RISE);
  wire m_r4 = (mode == MODE_CAP_R4);
  wire m_r16 = (mode == MODE_CAP_R16);
  wire is_cap = m_any | m_fall | m_rise | m_r4 | m_r16;
  wire m_tgl = (mode == MODE_CMP_TGL) | (mode == MODE_CMP_TGL_CLR);
  wire m_set = (mode == MODE_CMP_SET);
  wire m_clr = (mode == MODE_CMP_CLR);
  wire m_pls = (mode == MODE_CMP_PLS) | (mode == MODE_CMP_PLS_CLR);
  wire is_cmp = m_tgl | m_set | m_clr | m_pls; // [R23]
  wire clr_mode = (mode == MODE_CMP_TGL_CLR) | (mode == MODE_CMP_PLS_CLR); // [R20]

  // ****************************************
  // Timer selection
  // ****************************************
  // Reserved code falls back to the first timer
  wire sel_third = (cfg.tsel == TSEL_THIRD);
  wire sel_fifth = (cfg.tsel == TSEL_FIFTH);
  wire [15:0] tmr = sel_fifth ? timers.fifth :
                    sel_third ? timers.third : timers.first; // [R1] [R2] [R3]
  wire tmr_ext = sel_fifth ? timer_ext_clk[2] :
                 sel_third ? timer_ext_clk[1] : timer_ext_clk[0];
  // Frozen instruction-clocked timer stops captures, compares and prescaling in sleep
  wire awake = ~sleep_mode | tmr_ext; // [R17]

  // ****************************************
  // Trigger source and edges
  // ****************************************
  wire t_pin = (cfg.trig == TRIG_PIN);
  wire t_cmp1 = (cfg.trig == TRIG_CMP1);
  wire t_cmp2 = (cfg.trig == TRIG_CMP2);
  wire t_ioc = (cfg.trig == TRIG_IOC);
  // Pin path reads the pad, so the unit's own drive is seen too
  wire src_low = (t_pin & pin_sync) | (t_cmp1 & cmp_one) |
                 (t_cmp2 & cmp_two) | (t_ioc & pin_chg); // [R10] [R11]
  wire src_sel = cfg.trig[3] ? cells[cfg.trig[2:0]] : src_low; // [R11]
  wire rise = src_sel & ~src_prev;
  wire fall = ~src_sel & src_prev;
  wire hit4 = rise & (psc_cnt[1:0] == PSC4_LAST);
  wire hit16 = rise & (psc_cnt == PSC16_LAST);
  wire cap_evt = awake & ((m_fall & fall) | (m_rise & rise) |
                 (m_any & (rise | fall)) | (m_r4 & hit4) |
                 (m_r16 & hit16)); // [R6]

  // ****************************************
  // Compare
  // ****************************************
  wire match = is_cmp & (tmr == value);
  // Only the first cycle of a match acts, a held timer does not repeat
  wire cmp_evt = awake & match & ~match_prev; // [R18]

  // ****************************************
  // Next values
  // ****************************************
  wire [7:0] wr_lo_byte = wr_lo ? wbyte : value[7:0];
  wire [7:0] wr_hi_byte = wr_hi ? wbyte : value[15:8];
  wire [15:0] next_value = cap_evt ? tmr : {wr_hi_byte, wr_lo_byte}; // [R5] [R8]
  wire [3:0] next_psc = is_cap ? (psc_cnt + 4'h1) : 4'h0;
  wire latch_tgl = cmp_evt & m_tgl;
  wire latch_set = cmp_evt & (m_set | m_pls);
  wire latch_clr = (cmp_evt & m_clr) | (pulse_on & m_pls);
  wire next_latch = (mode == MODE_OFF) ? 1'b0 :
                    latch_tgl ? ~cmp_out :
                    latch_set ? 1'b1 :
                    latch_clr ? 1'b0 : cmp_out; // [R18] [R21]
  wire drive_en = is_cmp & ~cfg.ctrl.pin_dir;
  // Open drain only pulls low and releases for a high level
  wire next_oe = drive_en & (~cfg.ctrl.open_drain | ~next_latch); // [R4]
  wire next_pin = next_latch & ~cfg.ctrl.open_drain; // [R4]

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      src_prev <= 1'b0;
      psc_cnt <= 4'h0; // [R15]
      match_prev <= 1'b0;
      pulse_on <= 1'b0;
      value <= VALUE_RST;
      event_p <= 1'b0;
      tmr_clr <= 1'b0;
      conv_trig <= 1'b0;
      cmp_out <= 1'b0;
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end
    else
    begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
      src_prev <= src_sel;
      // Cleared outside capture, kept when only the qualifier changes
      if (!is_cap || (awake && rise))
      begin
        psc_cnt <= next_psc; // [R15] [R16]
      end
      match_prev <= match;
      pulse_on <= cmp_evt & m_pls;
      value <= next_value;
      event_p <= cap_evt | cmp_evt; // [R7] [R19]
      tmr_clr <= cmp_evt & clr_mode; // [R20]
      conv_trig <= cmp_evt & cfg.ctrl.conv_sel; // [R19]
      cmp_out <= next_latch; // [R22]
      pin_out <= next_pin;
      pin_oe <= next_oe;
    end
  end
endmodule

module ccu_top
  import ccu_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Unit pins
  input wire logic [1:0] unit_pin_in,
  output logic [1:0] unit_pin_out,
  output logic [1:0] unit_pin_oe,
  // Internal trigger sources
  input wire logic comparator_one_out,
  input wire logic comparator_two_out,
  input wire logic pin_change_interrupt,
  input wire logic [7:0] logic_cell_output,
  // Shared timers
  input wire ccu_pkg::ccu_timers_s selected_timer_count,
  input wire logic [2:0] timer_ext_clk,
  input wire logic sleep_mode,
  output logic [2:0] timer_clear,
  // Peripheral outputs
  output logic [1:0] conv_trigger,
  output logic [1:0] compare_out,
  output logic [1:0] unit_event_flag
);
  import ccu_pkg::*;

  // ****************************************
  // Register state
  // ****************************************
  ccu_ctrl_s unit_control_reg [2];
  logic [3:0] trigger_source_reg [2];
  logic [3:0] timer_select_reg;
  logic [1:0] unit_event_enable;
  ccu_cfg_s cfg [2];
  logic [15:0] capture_compare_value [2];
  logic [1:0] evt;
  logic [1:0] clr_req;
  logic [1:0] cmp_lat;

  // ****************************************
  // Write decode
  // ****************************************
  wire w_go = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
  wire w_b0 = w_go & s_axi_wstrb[0];
  wire w_unit = (s_axi_awaddr < UNIT_SPAN_END);
  wire w_idx = s_axi_awaddr[5];
  wire [4:0] w_ofs = s_axi_awaddr[4:0];
  wire w_ok = w_unit ? (w_ofs[1:0] == 2'h0 && w_ofs <= OFS_VHI) :
              (s_axi_awaddr == OFS_TSEL || s_axi_awaddr == OFS_PEND ||
               s_axi_awaddr == OFS_ENAB || s_axi_awaddr == OFS_STAT);
  wire [1:0] w_sel = {w_idx, ~w_idx};
  wire [1:0] wr_ctrl = (w_b0 & w_unit & (w_ofs == OFS_CTRL)) ? w_sel : 2'h0;
  wire [1:0] wr_trig = (w_b0 & w_unit & (w_ofs == OFS_TRIG)) ? w_sel : 2'h0;
  wire [1:0] wr_vlo = (w_b0 & w_unit & (w_ofs == OFS_VLO)) ? w_sel : 2'h0;
  wire [1:0] wr_vhi = (w_b0 & w_unit & (w_ofs == OFS_VHI)) ? w_sel : 2'h0;
  wire wr_tsel = w_b0 & (s_axi_awaddr == OFS_TSEL);
  wire wr_pend = w_b0 & (s_axi_awaddr == OFS_PEND);
  wire wr_enab = w_b0 & (s_axi_awaddr == OFS_ENAB);
  // Hardware set wins over a software clear in the same cycle
  wire [1:0] pend_clr = wr_pend ? s_axi_wdata[1:0] : 2'h0;
  wire [1:0] next_flag = (unit_event_flag & ~pend_clr) | evt; // [R7]

  // ****************************************
  // Read decode
  // ****************************************
  wire r_unit = (s_axi_araddr < UNIT_SPAN_END);
  wire r_idx = s_axi_araddr[5];
  wire [4:0] r_ofs = s_axi_araddr[4:0];
  wire [15:0] r_val = capture_compare_value[r_idx];
  wire [7:0] r_unit_data = (r_ofs == OFS_CTRL) ? {1'b0, unit_control_reg[r_idx]} :
                           (r_ofs == OFS_TRIG) ? {4'h0, trigger_source_reg[r_idx]} :
                           (r_ofs == OFS_VLO) ? r_val[7:0] :
                           (r_ofs == OFS_VHI) ? r_val[15:8] : 8'h00; // [R5]
  wire r_unit_ok = (r_ofs[1:0] == 2'h0) && (r_ofs <= OFS_VHI);
  wire [7:0] r_com_data = (s_axi_araddr == OFS_TSEL) ? {4'h0, timer_select_reg} :
                          (s_axi_araddr == OFS_PEND) ? {6'h00, unit_event_flag} :
                          (s_axi_araddr == OFS_ENAB) ? {6'h00, unit_event_enable} :
                          (s_axi_araddr == OFS_STAT) ? {6'h00, cmp_lat} : 8'h00;
  wire r_com_ok = (s_axi_araddr == OFS_TSEL) || (s_axi_araddr == OFS_PEND) ||
                  (s_axi_araddr == OFS_ENAB) || (s_axi_araddr == OFS_STAT);
  wire r_ok = r_unit ? r_unit_ok : r_com_ok;
  wire [7:0] r_data = r_unit ? r_unit_data : r_com_data;

  // ****************************************
  // Timer clear routing
  // ****************************************
  wire [1:0] ts0 = cfg[0].tsel;
  wire [1:0] ts1 = cfg[1].tsel;
  wire c0_third = (ts0 == TSEL_THIRD);
  wire c0_fifth = (ts0 == TSEL_FIFTH);
  wire c1_third = (ts1 == TSEL_THIRD);
  wire c1_fifth = (ts1 == TSEL_FIFTH);
  wire [2:0] clr0 = {c0_fifth, c0_third, ~c0_fifth & ~c0_third} & {3{clr_req[0]}};
  wire [2:0] clr1 = {c1_fifth, c1_third, ~c1_fifth & ~c1_third} & {3{clr_req[1]}};
  wire [2:0] next_tclr = clr0 | clr1; // [R20] [R3]

  // ****************************************
  // Units
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_unit
      assign cfg[gi] = '{ctrl: unit_control_reg[gi], trig: trigger_source_reg[gi],
                         tsel: timer_select_reg[2*gi+1:2*gi]}; // [R1]
      ccu_unit u_unit (
        .aclk(aclk),
        .aresetn(aresetn),
        .cfg(cfg[gi]),
        .timers(selected_timer_count),
        .timer_ext_clk(timer_ext_clk),
        .sleep_mode(sleep_mode),
        .pin_in(unit_pin_in[gi]),
        .cmp_one(comparator_one_out),
        .cmp_two(comparator_two_out),
        .pin_chg(pin_change_interrupt),
        .cells(logic_cell_output),
        .wr_lo(wr_vlo[gi]),
        .wr_hi(wr_vhi[gi]),
        .wbyte(s_axi_wdata[7:0]),
        .value(capture_compare_value[gi]),
        .event_p(evt[gi]),
        .tmr_clr(clr_req[gi]),
        .conv_trig(conv_trigger[gi]),
        .cmp_out(cmp_lat[gi]),
        .pin_out(unit_pin_out[gi]),
        .pin_oe(unit_pin_oe[gi])
      );
      assign compare_out[gi] = cmp_lat[gi]; // [R22]
    end
  endgenerate

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      unit_control_reg[0] <= CTRL_RST;
      unit_control_reg[1] <= CTRL_RST;
      trigger_source_reg[0] <= TRIG_RST;
      trigger_source_reg[1] <= TRIG_RST;
      timer_select_reg <= {TSEL_RST, TSEL_RST}; // [R1]
      unit_event_enable <= 2'h0;
      unit_event_flag <= 2'h0;
      timer_clear <= 3'h0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (wr_ctrl[i])
        begin
          unit_control_reg[i] <= s_axi_wdata[6:0];
        end
        if (wr_trig[i])
        begin
          trigger_source_reg[i] <= s_axi_wdata[3:0];
        end
      end
      if (wr_tsel)
      begin
        timer_select_reg <= s_axi_wdata[3:0];
      end
      if (wr_enab)
      begin
        unit_event_enable <= s_axi_wdata[1:0];
      end
      unit_event_flag <= next_flag;
      timer_clear <= next_tclr;
    end
  end

  // ****************************************
  // AXI4-Lite handshakes
  // ****************************************
  // Address and data are taken together, one write at a time
  wire w_take = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
  wire r_take = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= w_take;
      s_axi_wready <= w_take;
      if (w_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= r_take;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, r_data};
        s_axi_rresp <= r_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ==== bench/ccu_far.sv ====
`timescale 1ns/10ps
module ccu_far
  import ccu_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench control
  input wire logic run,
  input wire logic zap,
  // Timer side
  input wire logic [2:0] timer_clear,
  output ccu_pkg::ccu_timers_s timers
);
  // ****
  // Wide timers on the block clock, distinct rates
  // ****
  always_ff @(posedge aclk)
  begin
    if (!aresetn || zap)
      timers <= '0;
    else
    begin
      timers.first <= timer_clear[0] ? 16'h0 : timers.first + {15'h0, run};
      timers.third <= timer_clear[1] ? 16'h0 : timers.third + {14'h0, run, run};
      timers.fifth <= timer_clear[2] ? 16'h0 : timers.fifth + {13'h0, run, 1'h0, run};
    end
  end
endmodule

// ==== bench/ccu_monitor.sv ====
`timescale 1ns/10ps
module ccu_monitor
  import ccu_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register writes
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // Unit outputs
  input wire logic [2:0] timer_clear,
  input wire logic [1:0] conv_trigger,
  input wire logic [1:0] compare_out,
  input wire logic [1:0] unit_event_flag
);
  // ****
  // Decoded writes
  // ****
  wire logic take = s_axi_awready && s_axi_wstrb[0];
  wire logic w1c_0 = take && s_axi_awaddr == OFS_PEND && s_axi_wdata[0];
  wire logic w1c_1 = take && s_axi_awaddr == OFS_PEND && s_axi_wdata[1];
  wire logic off = take && s_axi_awaddr == 8'(OFS_CTRL) && s_axi_wdata[3:0] == MODE_OFF;
  default clocking mon_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ****
  // Properties
  // ****
  a_conv_single: assert property (conv_trigger[0] |=> !conv_trigger[0])
    else $error("conversion trigger too long");
  a_conv_flag: assert property (conv_trigger[0] |=> unit_event_flag[0])
    else $error("match without flag");
  a_clear_single: assert property (timer_clear[0] |=> !timer_clear[0])
    else $error("timer clear too long");
  a_clear_flag: assert property (timer_clear[0] |-> |unit_event_flag)
    else $error("timer clear without flag");
  a_flag_sticky: assert property ($fell(unit_event_flag[0]) |-> $past(w1c_0))
    else $error("flag 0 dropped by itself");
  a_flag_held: assert property ($fell(unit_event_flag[1]) |-> $past(w1c_1))
    else $error("flag 1 dropped by itself");
  a_off_latch: assert property (off |-> ##2 !compare_out[0])
    else $error("latch not forced low");
  a_rise_flag: assert property ($rose(compare_out[0]) |=> unit_event_flag[0])
    else $error("latch rose without flag");
endmodule
bind ccu_top ccu_monitor mon (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .timer_clear(timer_clear), .conv_trigger(conv_trigger), .compare_out(compare_out),
  .unit_event_flag(unit_event_flag));

// ==== bench/testbench.sv ====
`timescale 1ns/10ps
module testbench;
  import ccu_pkg::*;
  localparam logic [7:0] CT = 8'(OFS_CTRL), TR = 8'(OFS_TRIG), VL = 8'(OFS_VLO), VH = 8'(OFS_VHI);
  logic aclk = 1'h0, aresetn = 1'h0, run = 1'h0, zap = 1'h0, sleep = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [11:0] src = 12'h0;
  logic awrdy, wrdy, bvld, arrdy, rvld;
  logic [1:0] bresp, rresp, pout, poe, conv, cout, flag;
  logic [31:0] rdata, nclr, nconv;
  logic [2:0] tclr;
  logic [2:0] ext = 3'h0;
  ccu_timers_s tmr;
  logic [3:0] cmode [6] = '{4'h1, 4'h2, 4'h8, 4'h9, 4'hA, 4'hB};
  logic [1:0] cexp [6] = '{2'h3, 2'h1, 2'h1, 2'h0, 2'h0, 2'h2};
  logic [3:0] pmode [5] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
  int pneed [5] = '{1, 1, 1, 4, 16};
  int bad_count = 0;
  int n_checks = 0;
  int k;
  wire [3:0] rdy = {rvld, arrdy, bvld, awrdy};
  always #20 aclk = ~aclk;
  ccu_far far (.aclk(aclk), .aresetn(aresetn), .run(run), .zap(zap), .timer_clear(tclr),
    .timers(tmr));
  ccu_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awrdy), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bvld), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arrdy), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvld), .s_axi_rready(rready), .unit_pin_in({2{src[0]}}),
    .unit_pin_out(pout), .unit_pin_oe(poe), .comparator_one_out(src[1]),
    .comparator_two_out(src[2]), .pin_change_interrupt(src[3]), .logic_cell_output(src[11:4]),
    .selected_timer_count(tmr), .timer_ext_clk(ext), .sleep_mode(sleep), .timer_clear(tclr),
    .conv_trigger(conv), .compare_out(cout), .unit_event_flag(flag));
  // ****
  // Bus and check helpers
  // ****
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task go(input int s);
    for (k = 0; k < 60; k++)
    begin
      @(posedge aclk);
      if (rdy[s] === 1'h1)
        break;
    end
    if (k == 60)
    begin
      bad_count++;
      summarize;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    go(0);
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    go(1);
    bready <= 1'h0;
    chk(32'(bresp), 32'(r));
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = RESP_OKAY);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    go(2);
    arvalid <= 1'h0;
    go(3);
    rready <= 1'h0;
    chk(rdata, e);
    chk(32'(rresp), 32'(r));
  endtask
  task pulse(input logic [11:0] m);
    @(posedge aclk);
    src <= m;
    repeat (6) @(posedge aclk);
    src <= 12'h0;
    repeat (6) @(posedge aclk);
  endtask
  // ****
  // Scenarios
  // ****
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    rd(CT, 32'h20);
    rd(OFS_TSEL, 32'h0);
    rd(8'h50, 32'h0, RESP_SLVERR);
    wr(8'h50, 32'h1, RESP_SLVERR);
    foreach (cmode[j])
    begin
      wr(CT, 32'h0);
      rd(OFS_STAT, 32'h0);
      wr(OFS_PEND, 32'h3);
      wr(VL, 32'h6);
      wr(VH, 32'h0);
      @(posedge aclk) zap <= 1'h1;
      @(posedge aclk) zap <= 1'h0;
      wr(CT, {24'h0, 3'h2, j[0], cmode[j]});
      run <= 1'h1;
      nclr = 32'h0;
      nconv = 32'h0;
      for (int i = 0; i < 60 && flag[0] !== 1'h1; i++)
      begin
        @(posedge aclk);
        nclr = nclr + 32'(tclr[0]);
        nconv = nconv + 32'(conv[0]);
      end
      run <= 1'h0;
      chk(32'(flag[0]), 32'h1);
      chk(nconv, 32'h1);
      chk(nclr, 32'(cexp[j][1]));
      rd(OFS_STAT, 32'(cexp[j][0]));
      chk(32'({pout[0], poe[0]}), 32'(j[0] ? {1'h0, ~cexp[j][0]} : {cexp[j][0], 1'h1}));
      chk(32'(cout[0]), 32'(cexp[j][0]));
    end
    foreach (pmode[j])
    begin
      wr(CT, 32'h0);
      wr(TR, 32'h8);
      wr(CT, {24'h0, 4'h2, pmode[j]});
      wr(OFS_PEND, 32'h3);
      repeat (pneed[j] - 1) pulse(12'h010);
      rd(OFS_PEND, 32'h0);
      pulse(12'h010);
      rd(OFS_PEND, 32'h1);
    end
    for (int c = 0; c < 16; c++)
    begin
      if (c > 4 && c < 8)
        continue;
      wr(CT, 32'h0);
      wr(TR, 32'(c));
      wr(CT, 32'h25);
      wr(OFS_PEND, 32'h3);
      pulse(c == 4 ? 12'hFFF : 12'h001 << (c < 4 ? c : c - 4));
      rd(OFS_PEND, 32'(c != 4));
    end
    wr(OFS_TSEL, 32'h6);
    wr(UNIT_STRIDE + TR, 32'h8);
    wr(UNIT_STRIDE + CT, 32'h25);
    wr(TR, 32'h8);
    for (int q = 0; q < 2; q++)
    begin
      run <= 1'h1;
      repeat (9 + 5 * q) @(posedge aclk);
      run <= 1'h0;
      pulse(12'h010);
      rd(VL, 32'(tmr.fifth[7:0]));
      rd(VH, 32'(tmr.fifth[15:8]));
      rd(UNIT_STRIDE + VL, 32'(tmr.third[7:0]));
      rd(UNIT_STRIDE + VH, 32'(tmr.third[15:8]));
      rd(OFS_PEND, 32'h3);
      wr(OFS_PEND, 32'h3);
    end
    sleep <= 1'h1;
    ext <= 3'h4;
    pulse(12'h010);
    rd(OFS_PEND, 32'h1);
    sleep <= 1'h0;
    wr(OFS_PEND, 32'h3);
    rd(OFS_PEND, 32'h0);
    summarize;
  end
endmodule
